// [rtl/dual_port_eeprom_pkg.sv]
package dual_port_eeprom_pkg;

   // ---------------------------------------------------------------
   // Bus addresses (control bytes) seen on the display port
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_MEM_WR = 8'ha0;
   localparam logic [7:0] CTRL_MEM_RD = 8'ha1;
   localparam logic [7:0] CTRL_SEG_WR = 8'h60;
   localparam logic [7:0] CTRL_SEG_RD = 8'h61;
   localparam logic [7:0] CTRL_CFG_WR = 8'h62;
   localparam logic [7:0] CTRL_CFG_RD = 8'h63;

   // ---------------------------------------------------------------
   // port_bank_configuration field positions and reset values
   // ---------------------------------------------------------------
   localparam int CFG_SINGLE_BANK_BIT = 0;
   localparam int CFG_BANK_CHOICE_BIT = 1;
   localparam int CFG_BANK_SOURCE_BIT = 2;
   localparam int CFG_HOST_WE_BIT = 3;
   localparam logic [7:0] CFG_RESET = 8'hff;
   localparam logic [1:0] SEG_RESET = 2'h0;
   localparam logic [7:0] OFFSET_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Geometry and timing
   // ---------------------------------------------------------------
   localparam int SEG_COUNT = 4;
   localparam int SEG_BYTES = 256;
   localparam int BITS_PER_BYTE = 8;
   localparam int CLK_HZ = 25000000;
   localparam int ARB_HOLD_S = 1;
   localparam int ARB_HOLD_CYCLES = ARB_HOLD_S * CLK_HZ;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100
   } link_state_t;

   typedef enum logic [2:0] {
      K_CTRL = 3'b000,
      K_OFFSET = 3'b001,
      K_DATA = 3'b010,
      K_SEG = 3'b011,
      K_DUMMY = 3'b100,
      K_CFG = 3'b101,
      K_NONE = 3'b110
   } byte_kind_t;

   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_DSP = 2'b01,
      ARB_HOST = 2'b10
   } arb_state_t;

endpackage

// [rtl/dual_port_eeprom.sv]
`timescale 1ns/1ps

// Summary of operation
// - Without a segment pointer write, display port reaches segment 0 only.
// - Sequential offsets wrap within the current segment.
// - Segment pointer opens 1 KB as four 256-byte segments.
// - Two low bits of the segment byte pick the segment; rest ignored.
// - Idle ports with both clocks high: arbiter holds nothing.
// - START on one port pulls the other port's clock low.
// - Release the held clock after initiator clock is high one second.
// - Config bit 0 set means one bank, lower bank only.
// - Config bit 3 enables host-port writes.
// - Host write enable never blocks display port writes.
// - Two banks, bit 2 clear: bank select pin picks the bank.
// - Two banks, bit 2 set: config bit 1 picks the bank.
// - Config register at 62h write, 63h read, from the display port only.
// - Config write: control 62h, dummy byte, data byte, each acked.
// - Config read: control 63h, one data byte, master nacks.
// - Segment pointer write-only at 60h; 61h access undefined.
// - Config register starts erased, all ones.
// - Host memory writes refused unless host write enable is set.
module dual_port_eeprom
   import dual_port_eeprom_pkg::*;
#(
   parameter int HOLD_CYCLES = ARB_HOLD_CYCLES,
   parameter int HOLD_W = 25
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic dsp_scl_in,
   output logic dsp_scl_out,
   output logic dsp_scl_oe,
   input wire logic dsp_sda_in,
   output logic dsp_sda_out,
   output logic dsp_sda_oe,
   input wire logic host_port_clock_line_in,
   output logic host_port_clock_line_out,
   output logic host_port_clock_line_oe,
   input wire logic host_sda_in,
   input wire logic bank_select_pin,
   input wire logic host_wr_req,
   output logic host_wr_grant,
   output logic host_bank_upper,
   output logic single_bank_map,
   output logic host_write_enable
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [3:0] prev_r;
   logic dsp_scl_s, dsp_sda_s, host_scl_s, host_sda_s, bank_pin_s;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= 5'h1f;
         sync2_r <= 5'h1f;
         prev_r <= 4'hf;
      end else begin
         sync1_r <= {bank_select_pin, host_sda_in, host_port_clock_line_in,
                     dsp_sda_in, dsp_scl_in};
         sync2_r <= sync1_r;
         prev_r <= sync2_r[3:0];
      end
   end

   assign dsp_scl_s = sync2_r[0];
   assign dsp_sda_s = sync2_r[1];
   assign host_scl_s = sync2_r[2];
   assign host_sda_s = sync2_r[3];
   assign bank_pin_s = sync2_r[4];

   logic scl_rise, scl_fall, dsp_start, dsp_stop, host_start;

   assign scl_rise = dsp_scl_s & ~prev_r[0];
   assign scl_fall = ~dsp_scl_s & prev_r[0];
   assign dsp_start = dsp_scl_s & prev_r[0] & prev_r[1] & ~dsp_sda_s;
   assign dsp_stop = dsp_scl_s & prev_r[0] & ~prev_r[1] & dsp_sda_s;
   assign host_start = host_scl_s & prev_r[2] & prev_r[3] & ~host_sda_s;

   // ---------------------------------------------------------------
   // Port arbitration
   // ---------------------------------------------------------------
   arb_state_t arb_r;
   logic [HOLD_W-1:0] hold_cnt_r;
   logic init_scl;

   assign init_scl = (arb_r == ARB_DSP) ? dsp_scl_s : host_scl_s;

   // Display port wins a tie; the scheme is simple, not collision proof
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         arb_r <= ARB_IDLE;
         hold_cnt_r <= '0;
      end else begin
         unique case (arb_r)
            ARB_IDLE: begin
               hold_cnt_r <= '0;
               if (dsp_start) begin
                  arb_r <= ARB_DSP;
               end else if (host_start) begin
                  arb_r <= ARB_HOST;
               end
            end
            ARB_DSP, ARB_HOST: begin
               if (!init_scl) begin
                  hold_cnt_r <= '0;
               end else if (hold_cnt_r == HOLD_W'(HOLD_CYCLES - 1)) begin
                  arb_r <= ARB_IDLE;
                  hold_cnt_r <= '0;
               end else begin
                  hold_cnt_r <= hold_cnt_r + 1'b1;
               end
            end
            default: begin
               arb_r <= ARB_IDLE;
               hold_cnt_r <= '0;
            end
         endcase
      end
   end

   // Open-drain clocks: only ever pulled low, never driven high
   assign host_port_clock_line_out = 1'b0;
   assign host_port_clock_line_oe = (arb_r == ARB_DSP);
   assign dsp_scl_out = 1'b0;
   assign dsp_scl_oe = (arb_r == ARB_HOST);

   // ---------------------------------------------------------------
   // Display port byte engine
   // ---------------------------------------------------------------
   link_state_t st_r;
   byte_kind_t kind_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic rd_r;
   logic rd_cfg_r;
   logic ack_seen_r;
   logic [1:0] seg_r;
   logic [7:0] off_r;
   logic [7:0] cfg_r;
   logic [7:0] mem [SEG_COUNT*SEG_BYTES];
   logic [7:0] rd_byte;
   logic byte_done;
   logic ctrl_ok;
   logic mem_we;

   assign byte_done = (st_r == ST_RX) && scl_fall &&
                      (bit_cnt_r == 4'(BITS_PER_BYTE));
   assign rd_byte = rd_cfg_r ? cfg_r : mem[{seg_r, off_r}];
   assign mem_we = byte_done && (kind_r == K_DATA);

   // Control byte 61h is not answered: reads of the pointer are undefined
   always_comb begin
      ctrl_ok = 1'b0;
      unique case (shift_r)
         CTRL_MEM_WR, CTRL_MEM_RD: ctrl_ok = 1'b1;
         CTRL_SEG_WR: ctrl_ok = 1'b1;
         CTRL_CFG_WR, CTRL_CFG_RD: ctrl_ok = 1'b1;
         default: ctrl_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_IDLE;
         kind_r <= K_CTRL;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         rd_r <= 1'b0;
         rd_cfg_r <= 1'b0;
         ack_seen_r <= 1'b0;
      end else if (dsp_stop) begin
         st_r <= ST_IDLE;
      end else if (dsp_start) begin
         st_r <= ST_RX;
         kind_r <= K_CTRL;
         bit_cnt_r <= 4'h0;
         rd_r <= 1'b0;
         rd_cfg_r <= 1'b0;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               bit_cnt_r <= 4'h0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], dsp_sda_s};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (byte_done) begin
                  st_r <= ST_RX_ACK;
                  unique case (kind_r)
                     K_CTRL: begin
                        if (!ctrl_ok) begin
                           st_r <= ST_IDLE;
                        end
                        rd_r <= (shift_r == CTRL_MEM_RD) ||
                                (shift_r == CTRL_CFG_RD);
                        rd_cfg_r <= (shift_r == CTRL_CFG_RD);
                        if (shift_r == CTRL_SEG_WR) begin
                           kind_r <= K_SEG;
                        end else if (shift_r == CTRL_CFG_WR) begin
                           kind_r <= K_DUMMY;
                        end else begin
                           kind_r <= K_OFFSET;
                        end
                     end
                     K_OFFSET: kind_r <= K_DATA;
                     K_SEG: kind_r <= K_NONE;
                     K_DUMMY: kind_r <= K_CFG;
                     K_CFG: kind_r <= K_NONE;
                     K_DATA, K_NONE: kind_r <= kind_r;
                     default: kind_r <= K_NONE;
                  endcase
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (rd_r) begin
                     st_r <= ST_TX;
                     shift_r <= rd_byte;
                  end else begin
                     st_r <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == 4'(BITS_PER_BYTE)) begin
                     st_r <= ST_TX_ACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  ack_seen_r <= ~dsp_sda_s;
               end else if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (ack_seen_r) begin
                     st_r <= ST_TX;
                     shift_r <= rd_byte;
                  end else begin
                     st_r <= ST_IDLE;
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Segment pointer and byte offset
   // ---------------------------------------------------------------
   // Pointer is volatile and dropped at STOP so plain accesses see seg 0
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         seg_r <= SEG_RESET;
      end else if (dsp_stop) begin
         seg_r <= SEG_RESET;
      end else if (byte_done && kind_r == K_SEG) begin
         seg_r <= shift_r[1:0];
      end
   end

   // Offset is 8 bits, so increments wrap inside the segment
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         off_r <= OFFSET_RESET;
      end else if (byte_done && kind_r == K_OFFSET) begin
         off_r <= shift_r;
      end else if (mem_we) begin
         off_r <= off_r + 8'h01;
      end else if (st_r == ST_TX && scl_fall && !rd_cfg_r &&
                   bit_cnt_r == 4'(BITS_PER_BYTE)) begin
         off_r <= off_r + 8'h01;
      end
   end

   // Memory has no reset; page length is the master's business
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem[{seg_r, off_r}] <= shift_r;
      end
   end

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   // Stands in for the non-volatile cell: reset restores the erased value
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= CFG_RESET;
      end else if (byte_done && kind_r == K_CFG) begin
         cfg_r[3:0] <= shift_r[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Display port data line
   // ---------------------------------------------------------------
   assign dsp_sda_out = 1'b0;
   assign dsp_sda_oe = (st_r == ST_RX_ACK) ||
                       (st_r == ST_TX && !shift_r[7]);

   // ---------------------------------------------------------------
   // Host port map
   // ---------------------------------------------------------------
   assign single_bank_map = cfg_r[CFG_SINGLE_BANK_BIT];
   assign host_write_enable = cfg_r[CFG_HOST_WE_BIT];
   assign host_wr_grant = host_wr_req && cfg_r[CFG_HOST_WE_BIT];

   always_comb begin
      if (cfg_r[CFG_SINGLE_BANK_BIT]) begin
         host_bank_upper = 1'b0;
      end else if (cfg_r[CFG_BANK_SOURCE_BIT]) begin
         host_bank_upper = cfg_r[CFG_BANK_CHOICE_BIT];
      end else begin
         host_bank_upper = bank_pin_s;
      end
   end

endmodule // dual_port_eeprom

// [verif/dual_port_eeprom_monitor.sv]
`timescale 1ns/1ps
module dual_port_eeprom_monitor
   import dual_port_eeprom_pkg::*;
#(
   parameter int HOLD_CYCLES = ARB_HOLD_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic dsp_scl_in,
   input wire logic dsp_sda_in,
   input wire logic dsp_scl_oe,
   input wire logic host_port_clock_line_in,
   input wire logic host_sda_in,
   input wire logic host_port_clock_line_oe,
   input wire logic host_wr_req,
   input wire logic host_wr_grant,
   input wire logic host_bank_upper,
   input wire logic single_bank_map,
   input wire logic host_write_enable
);
   // Synchroniser delay plus the release clock
   localparam int SLACK = 8;
   logic dsda_r, hsda_r, dsp_st, host_st;
   int dcnt_r, hcnt_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   assign dsp_st = dsp_scl_in & dsda_r & ~dsp_sda_in;
   assign host_st = host_port_clock_line_in & hsda_r & ~host_sda_in;
   // ---------------------------------------------
   // Initiator clock high run, restarted by a claim
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dsda_r <= 1'h1;
         hsda_r <= 1'h1;
         dcnt_r <= 0;
         hcnt_r <= 0;
      end else begin
         dsda_r <= dsp_sda_in;
         hsda_r <= host_sda_in;
         dcnt_r <= (!dsp_scl_in || (dsp_st && !host_port_clock_line_oe))
            ? 0 : dcnt_r + 1;
         hcnt_r <= (!host_port_clock_line_in || (host_st && !dsp_scl_oe))
            ? 0 : hcnt_r + 1;
      end
   end
   sequence dsp_start_s;
      dsp_st ##0 !dsp_scl_oe;
   endsequence
   sequence host_start_s;
      host_st ##0 !host_port_clock_line_oe;
   endsequence
   dual_hold_a: assert property (
      !(dsp_scl_oe && host_port_clock_line_oe))
      else $error("both clock lines held");
   dsp_claim_a: assert property (
      dsp_start_s |-> ##[1:6] host_port_clock_line_oe)
      else $error("host clock not held after display start");
   host_claim_a: assert property (
      host_start_s |-> ##[1:6] dsp_scl_oe)
      else $error("display clock not held after host start");
   host_early_a: assert property (
      $fell(host_port_clock_line_oe) |-> dcnt_r >= HOLD_CYCLES)
      else $error("host clock released early");
   host_late_a: assert property (
      host_port_clock_line_oe |-> dcnt_r <= HOLD_CYCLES + SLACK)
      else $error("host clock released late");
   dsp_early_a: assert property (
      $fell(dsp_scl_oe) |-> hcnt_r >= HOLD_CYCLES)
      else $error("display clock released early");
   dsp_late_a: assert property (
      dsp_scl_oe |-> hcnt_r <= HOLD_CYCLES + SLACK)
      else $error("display clock released late");
   grant_gate_a: assert property (
      host_wr_grant == (host_wr_req && host_write_enable))
      else $error("host write grant wrong");
   lower_only_a: assert property (
      single_bank_map |-> !host_bank_upper)
      else $error("upper bank in single bank map");
endmodule // dual_port_eeprom_monitor

bind dual_port_eeprom dual_port_eeprom_monitor
   #(.HOLD_CYCLES(HOLD_CYCLES)) i_mon (
   .clk_sys(clk_sys), .rst_b(rst_b), .dsp_scl_in(dsp_scl_in),
   .dsp_sda_in(dsp_sda_in), .dsp_scl_oe(dsp_scl_oe),
   .host_port_clock_line_in(host_port_clock_line_in),
   .host_sda_in(host_sda_in),
   .host_port_clock_line_oe(host_port_clock_line_oe),
   .host_wr_req(host_wr_req), .host_wr_grant(host_wr_grant),
   .host_bank_upper(host_bank_upper), .single_bank_map(single_bank_map),
   .host_write_enable(host_write_enable)
);

// [verif/i2c_master_model.sv]
`timescale 1ns/1ps
module i2c_master_model #(
   parameter int HALF = 4
) (
   input wire logic clk,
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_drv,
   output logic sda_drv
);
   // ---------------------------------------------
   // Open-drain master, lines released high
   // ---------------------------------------------
   initial begin
      scl_drv = 1'h1;
      sda_drv = 1'h1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // A held clock stretches the low phase; bounded so a stuck hold ends
   task automatic rise();
      int k;
      k = 0;
      scl_drv <= 1'h1;
      @(posedge clk);
      while (!scl_line && k < 4000) begin
         @(posedge clk);
         k++;
      end
      tick(HALF - 1);
   endtask
   task automatic bit_io(input logic b, output logic r);
      tick(HALF / 2);
      sda_drv <= b;
      tick(HALF / 2);
      rise();
      r = sda_line;
      scl_drv <= 1'h0;
   endtask
   // Full low phase first: the slave drops its ACK 3-4 cycles late, and
   // raising the clock before that would read as a STOP
   task automatic start();
      sda_drv <= 1'h1;
      tick(HALF);
      rise();
      sda_drv <= 1'h0;
      tick(HALF);
      scl_drv <= 1'h0;
   endtask
   task automatic stop();
      tick(HALF / 2);
      sda_drv <= 1'h0;
      tick(HALF / 2);
      rise();
      sda_drv <= 1'h1;
      tick(HALF);
   endtask
   task automatic put_byte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'h1, nack);
   endtask
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   endtask
endmodule // i2c_master_model

// [verif/dual_port_eeprom_tb.sv]
`timescale 1ns/1ps
module dual_port_eeprom_tb
   import dual_port_eeprom_pkg::*;
;
   localparam int HOLD = 200;
   localparam int LIMIT = 20000;
   logic clk_sys, rst_b, bank_select_pin, host_wr_req, nk, ack_or;
   logic dsp_scl_oe, dsp_sda_oe, host_port_clock_line_oe, host_wr_grant;
   logic host_bank_upper, single_bank_map, host_write_enable;
   logic ds_c, ds_d, hs_c, hs_d;
   wire dsp_scl, dsp_sda, host_scl;
   wire [2:0] lo;
   int n_mismatch, n_checks, cyc;
   logic [7:0] d0, d1;
   logic [3:0] nib_t [5] = '{4'h9, 4'h0, 4'h0, 4'h4, 4'h6};
   logic pin_t [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
   logic up_t [5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
   assign dsp_scl = ds_c & ~dsp_scl_oe;
   assign dsp_sda = ds_d & ~dsp_sda_oe;
   assign host_scl = hs_c & ~host_port_clock_line_oe;
   dual_port_eeprom #(.HOLD_CYCLES(HOLD)) i_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .dsp_scl_in(dsp_scl),
      .dsp_scl_out(lo[0]), .dsp_scl_oe(dsp_scl_oe), .dsp_sda_in(dsp_sda),
      .dsp_sda_out(lo[1]), .dsp_sda_oe(dsp_sda_oe),
      .host_port_clock_line_in(host_scl),
      .host_port_clock_line_out(lo[2]),
      .host_port_clock_line_oe(host_port_clock_line_oe),
      .host_sda_in(hs_d), .bank_select_pin(bank_select_pin),
      .host_wr_req(host_wr_req), .host_wr_grant(host_wr_grant),
      .host_bank_upper(host_bank_upper), .single_bank_map(single_bank_map),
      .host_write_enable(host_write_enable)
   );
   i2c_master_model i_dsp (.clk(clk_sys), .scl_line(dsp_scl),
      .sda_line(dsp_sda), .scl_drv(ds_c), .sda_drv(ds_d));
   i2c_master_model i_host (.clk(clk_sys), .scl_line(host_scl),
      .sda_line(hs_d), .scl_drv(hs_c), .sda_drv(hs_d));
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ---------------------------------------------
   // Access tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic pb(input logic [7:0] d);
      i_dsp.put_byte(d, nk);
      ack_or = ack_or | nk;
   endtask
   task automatic open_at(input logic seg_on, input logic [7:0] seg,
                          input logic [7:0] off);
      i_dsp.start();
      if (seg_on) begin
         pb(CTRL_SEG_WR);
         pb(seg);
         i_dsp.start();
      end
      pb(CTRL_MEM_WR);
      pb(off);
   endtask
   task automatic cfg_rd(output logic [7:0] d);
      i_dsp.start();
      pb(CTRL_CFG_RD);
      i_dsp.get_byte(1'h1, d);
      i_dsp.stop();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_b = 1'h0;
      bank_select_pin = 1'h0;
      host_wr_req = 1'h0;
      ack_or = 1'h0;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'h1;
      repeat (5) @(posedge clk_sys);
      chk("bank map", 8'h01, {7'h0, single_bank_map});
      chk("write enable", 8'h01, {7'h0, host_write_enable});
      chk("held clocks", 8'h00,
          {6'h0, dsp_scl_oe, host_port_clock_line_oe});
      // Open-drain pins may only ever pull low
      chk("pull levels", 8'h00, {5'h0, lo});
      cfg_rd(d0);
      chk("config", 8'hff, d0);
      foreach (nib_t[i]) begin
         bank_select_pin <= pin_t[i];
         host_wr_req <= 1'h1;
         i_dsp.start();
         pb(CTRL_CFG_WR);
         pb(8'h00);
         pb({4'h0, nib_t[i]});
         i_dsp.stop();
         cfg_rd(d0);
         chk("config", {4'hf, nib_t[i]}, d0);
         chk("upper bank", {7'h0, up_t[i]}, {7'h0, host_bank_upper});
         chk("single bank", {7'h0, nib_t[i][0]},
             {7'h0, single_bank_map});
         chk("grant", {7'h0, nib_t[i][3]}, {7'h0, host_wr_grant});
      end
      // Host writes now disabled; display writes must still land
      for (int s = 0; s < 4; s++) begin
         open_at(1'h1, 8'hfc | s[7:0], 8'hff);
         pb(8'h50 + s[7:0]);
         pb(8'h60 + s[7:0]);
         i_dsp.stop();
      end
      for (int s = 0; s < 5; s++) begin
         open_at(s < 4, s[7:0], 8'hff);
         i_dsp.start();
         pb(CTRL_MEM_RD);
         i_dsp.get_byte(1'h0, d0);
         i_dsp.get_byte(1'h1, d1);
         i_dsp.stop();
         chk("segment data", 8'h50 + s[1:0], d0);
         chk("wrapped data", 8'h60 + s[1:0], d1);
      end
      chk("acks", 8'h00, {7'h0, ack_or});
      i_dsp.start();
      i_dsp.put_byte(CTRL_SEG_RD, nk);
      i_dsp.stop();
      chk("reserved ack", 8'h01, {7'h0, nk});
      repeat (HOLD + 20) @(posedge clk_sys);
      chk("held clocks", 8'h00,
          {6'h0, dsp_scl_oe, host_port_clock_line_oe});
      i_host.start();
      repeat (4) @(posedge clk_sys);
      chk("display held", 8'h01, {7'h0, dsp_scl_oe});
      i_host.stop();
      cfg_rd(d0);
      chk("config after hold", 8'hf6, d0);
      print_verdict();
   end
endmodule // dual_port_eeprom_tb
